// >>> hw/phe_mem.sv
/*
  small register-file memory for outstanding prefetch entries.
  assumes one write and one read per cycle; read data come out of a register.
*/
module phe_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [phe_pkg::PHE_TAG_W-1:0] wr_idx,
  input wire logic [phe_pkg::PHE_ENT_W-1:0] wr_data,
  input wire logic [phe_pkg::PHE_TAG_W-1:0] rd_idx,
  output logic [phe_pkg::PHE_ENT_W-1:0] rd_data
);

  // ********************************
  // storage
  // ********************************
  logic [phe_pkg::PHE_ENT_W-1:0] mem_r [phe_pkg::PHE_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  // ********************************
  // registered read
  // ********************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= phe_pkg::PHE_ENT_RST;
    end else begin
      rd_data <= mem_r[rd_idx];
    end
  end

endmodule

// >>> hw/phe_top.sv
/*
  prefetch hint decode and execution: address and space formation, variant
  decode, exception and no-op filtering, translation and fill request issue.
  assumes the translation unit takes every request pulse and answers each
  tag exactly once; the cache and mapping units take every request pulse.
*/
module phe_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic alt_form,
  input wire logic [63:0] first_source_register,
  input wire logic [63:0] second_source_register,
  input wire logic [7:0] space_id_register,
  input wire logic priv_mode,
  input wire logic little_endian,
  output logic illegal_instr,
  output logic noop_done,
  output logic xlate_req_valid,
  output logic [63:0] xlate_req_addr,
  output logic [7:0] xlate_req_space,
  output logic [1:0] xlate_req_tag,
  input wire logic xlate_rsp_valid,
  input wire logic [1:0] xlate_rsp_tag,
  input wire logic xlate_rsp_miss,
  input wire logic xlate_rsp_slow,
  input wire logic physically_cacheable_flag,
  input wire logic virtually_cacheable_flag,
  input wire logic side_effect_flag,
  input wire logic [63:0] xlate_rsp_paddr,
  output logic fill_req_valid,
  output logic [63:0] fill_req_addr,
  output logic fill_req_write,
  output logic fill_req_once,
  output logic fill_req_unified,
  output logic fill_req_strong,
  output logic map_req_valid,
  output logic [63:0] map_req_addr,
  output logic [7:0] map_req_space,
  output logic late_drop
);

  // ********************************
  // reset release
  // ********************************
  logic rst_s1_r;
  logic rst_s2_r;
  // the core wakes two edges after the pin rises, so the release never
  // races the first issue against half-cleared pipeline flops
  wire logic rstn_i = rst_s2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ********************************
  // decode functions
  // ********************************
  function automatic phe_pkg::phe_cls_t phe_class(input logic [4:0] fcn);
    phe_pkg::phe_cls_t c;
    c = phe_pkg::PHE_CLS_NOP;
    if (fcn >= phe_pkg::PHE_FCN_RSV_LO && fcn <= phe_pkg::PHE_FCN_RSV_HI) begin
      c = phe_pkg::PHE_CLS_ILLEGAL;
    end else if (!phe_pkg::PHE_IMPL_MASK[fcn]) begin
      c = phe_pkg::PHE_CLS_NOP;
    end else if (fcn[4:2] == 3'b000) begin
      c = phe_pkg::PHE_CLS_WEAK;
    end else if (fcn[4:2] == 3'b101) begin
      c = phe_pkg::PHE_CLS_STRONG;
    end else if (fcn == phe_pkg::PHE_FCN_PAGE) begin
      c = phe_pkg::PHE_CLS_PAGE;
    end else if (fcn == phe_pkg::PHE_FCN_UNIFIED) begin
      c = phe_pkg::PHE_CLS_UNIFIED;
    end
    return c;
  endfunction

  // any identifier outside the eight listed ones is invalid for the hint
  function automatic logic space_ok(input logic [7:0] s);
    logic ok;
    ok = 1'b0;
    if (s == phe_pkg::PHE_NUCLEUS_SPACE) begin
      ok = 1'b1;
    end else if (s == phe_pkg::PHE_USER_VIEW_PRIMARY_SPACE) begin
      ok = 1'b1;
    end else if (s == phe_pkg::PHE_USER_VIEW_SECONDARY_SPACE) begin
      ok = 1'b1;
    end else if (s == phe_pkg::PHE_PRIMARY_SPACE) begin
      ok = 1'b1;
    end else if (s == phe_pkg::PHE_SECONDARY_SPACE) begin
      ok = 1'b1;
    end else if (s == phe_pkg::PHE_PRIMARY_NOFAULT_SPACE) begin
      ok = 1'b1;
    end else if (s == phe_pkg::PHE_SECONDARY_NOFAULT_SPACE) begin
      ok = 1'b1;
    end else if (s == phe_pkg::PHE_REAL_SPACE) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // ********************************
  // issue decode
  // ********************************
  wire logic imm_sel = instr[phe_pkg::PHE_IFLAG_POS];
  wire logic [4:0] fcn = instr[phe_pkg::PHE_FCN_HI:phe_pkg::PHE_FCN_LO];
  wire logic [7:0] asi_field = instr[phe_pkg::PHE_ASIF_HI:phe_pkg::PHE_ASIF_LO];
  wire logic [12:0] imm13 = instr[phe_pkg::PHE_IMM_HI:0];
  wire logic [63:0] signed_short_immediate = 64'($signed(imm13));
  wire logic [63:0] addend = imm_sel ? signed_short_immediate
                                     : second_source_register;
  wire logic [63:0] eff_addr = first_source_register + addend;

  wire logic [7:0] primary_pick = little_endian ? phe_pkg::PHE_PRIMARY_LITTLE_SPACE
                                                : phe_pkg::PHE_PRIMARY_SPACE;
  wire logic [7:0] alt_pick = imm_sel ? space_id_register : asi_field;
  wire logic [7:0] space = alt_form ? alt_pick : primary_pick;

  wire phe_pkg::phe_cls_t cls = phe_class(fcn);

  // the register-form check covers the ordinary form only: in the alternate
  // form those bits carry the space field
  wire logic bad_fmt = !alt_form && !imm_sel && (asi_field != 8'h00);
  wire logic is_illegal = (cls == phe_pkg::PHE_CLS_ILLEGAL) || bad_fmt;

  wire logic low_space = space <= phe_pkg::PHE_SPACE_PRIV_TOP;
  wire logic hyp_space = low_space && (space >= phe_pkg::PHE_SPACE_HYP_LO);
  wire logic user_fail = !priv_mode && low_space;
  wire logic priv_fail = priv_mode && hyp_space;
  wire logic space_fail = alt_form && (user_fail || priv_fail);
  wire logic asi_fail = alt_form && !space_ok(space);

  // page and unified codes go out for translation like weak and strong ones
  wire logic acts = (cls == phe_pkg::PHE_CLS_WEAK) ||
                    (cls == phe_pkg::PHE_CLS_STRONG) ||
                    (cls == phe_pkg::PHE_CLS_PAGE) ||
                    (cls == phe_pkg::PHE_CLS_UNIFIED);

  // ********************************
  // outstanding table allocation
  // ********************************
  logic [phe_pkg::PHE_DEPTH-1:0] busy_r;
  logic [phe_pkg::PHE_DEPTH-1:0] busy_nxt;
  logic [phe_pkg::PHE_DEPTH-1:0] free_vec;
  logic [phe_pkg::PHE_TAG_W-1:0] free_idx;

  genvar gi;
  generate
    for (gi = 0; gi < phe_pkg::PHE_DEPTH; gi++) begin : g_free
      assign free_vec[gi] = !busy_r[gi];
    end
  endgenerate

  always_comb begin
    free_idx = '0;
    for (int i = phe_pkg::PHE_DEPTH - 1; i >= 0; i--) begin
      if (free_vec[i]) begin
        free_idx = phe_pkg::PHE_TAG_W'(i);
      end
    end
  end

  // a full table drops the hint instead of stalling issue
  wire logic table_full = (free_vec == '0);
  wire logic go = issue_valid && !is_illegal && acts && !space_fail &&
                  !asi_fail && !table_full;
  wire logic quiet = issue_valid && !is_illegal && !go;

  wire logic [phe_pkg::PHE_VBLK_W-1:0] vblk =
    eff_addr[phe_pkg::PHE_XLEN-1:phe_pkg::PHE_BLK_BITS];
  wire logic [phe_pkg::PHE_ENT_W-1:0] ent_wr = {space, fcn, vblk};
  wire logic [phe_pkg::PHE_XLEN-1:0] req_addr = {vblk, phe_pkg::PHE_BLK_BITS'(0)};

  // ********************************
  // issue outputs
  // ********************************
  // exactly one of the three pulses follows each issue, one edge later
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      illegal_instr <= 1'b0;
      noop_done <= 1'b0;
      xlate_req_valid <= 1'b0;
    end else begin
      illegal_instr <= issue_valid && is_illegal;
      noop_done <= quiet;
      xlate_req_valid <= go;
    end
  end

  // the request word follows every cycle; only the valid pulse qualifies it
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      xlate_req_addr <= phe_pkg::PHE_ADDR_RST;
      xlate_req_space <= phe_pkg::PHE_SPACE_RST;
      xlate_req_tag <= phe_pkg::PHE_TAG_RST;
    end else begin
      xlate_req_addr <= req_addr;
      xlate_req_space <= space;
      xlate_req_tag <= free_idx;
    end
  end

  // ********************************
  // translation answer stage
  // ********************************
  logic s1_valid_r;
  logic s1_miss_r;
  logic s1_slow_r;
  logic s1_badc_r;
  logic [phe_pkg::PHE_TAG_W-1:0] s1_tag_r;
  logic [63:0] s1_paddr_r;
  logic [phe_pkg::PHE_ENT_W-1:0] ent_rd;

  wire logic badc_in = !physically_cacheable_flag ||
                       !virtually_cacheable_flag || side_effect_flag;

  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_valid_r <= 1'b0;
      s1_miss_r <= 1'b0;
      s1_slow_r <= 1'b0;
      s1_badc_r <= 1'b0;
      s1_tag_r <= phe_pkg::PHE_TAG_RST;
      s1_paddr_r <= phe_pkg::PHE_ADDR_RST;
    end else begin
      s1_valid_r <= xlate_rsp_valid;
      s1_miss_r <= xlate_rsp_miss;
      s1_slow_r <= xlate_rsp_slow;
      s1_badc_r <= badc_in;
      s1_tag_r <= xlate_rsp_tag;
      s1_paddr_r <= xlate_rsp_paddr;
    end
  end

  // the entry read by answer tag lines up with the registered answer flags
  phe_mem u_mem (
    .clk(clk),
    .rst_n(rstn_i),
    .wr_en(go),
    .wr_idx(free_idx),
    .wr_data(ent_wr),
    .rd_idx(xlate_rsp_tag),
    .rd_data(ent_rd)
  );

  // ********************************
  // completion decision
  // ********************************
  wire logic [7:0] rd_space = ent_rd[phe_pkg::PHE_ENT_W-1 -: 8];
  wire logic [4:0] rd_fcn = ent_rd[phe_pkg::PHE_VBLK_W +: 5];
  wire logic [phe_pkg::PHE_VBLK_W-1:0] rd_vblk = ent_rd[phe_pkg::PHE_VBLK_W-1:0];
  // the class is decoded again from the stored code rather than stored,
  // which keeps each table entry narrow
  wire phe_pkg::phe_cls_t cls2 = phe_class(rd_fcn);

  wire logic is_weak = cls2 == phe_pkg::PHE_CLS_WEAK;
  wire logic is_strong = cls2 == phe_pkg::PHE_CLS_STRONG;
  wire logic is_page = cls2 == phe_pkg::PHE_CLS_PAGE;
  wire logic is_uni = cls2 == phe_pkg::PHE_CLS_UNIFIED;

  // weak and page give up on slow work, strong and unified go on
  wire logic weak_drop = is_weak && (s1_miss_r || s1_slow_r);
  wire logic cache_drop = !s1_miss_r && s1_badc_r;
  wire logic data_ok = (is_weak || is_strong || is_uni) && !s1_miss_r &&
                       !cache_drop && !weak_drop;
  wire logic map_ok = is_page && s1_miss_r && !s1_slow_r;
  wire logic do_fill = s1_valid_r && data_ok;
  wire logic do_map = s1_valid_r && map_ok;
  wire logic do_drop = s1_valid_r && !data_ok && !map_ok;

  // unified fills carry no read or write intent of their own
  wire logic fill_write = !is_uni && rd_fcn[1];
  wire logic fill_once = !is_uni && rd_fcn[0];
  wire logic [63:0] fill_blk = {s1_paddr_r[63:phe_pkg::PHE_BLK_BITS],
                                phe_pkg::PHE_BLK_BITS'(0)};

  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      fill_req_valid <= 1'b0;
      fill_req_addr <= phe_pkg::PHE_ADDR_RST;
      fill_req_write <= 1'b0;
      fill_req_once <= 1'b0;
      fill_req_unified <= 1'b0;
      fill_req_strong <= 1'b0;
    end else begin
      fill_req_valid <= do_fill;
      fill_req_addr <= fill_blk;
      fill_req_write <= fill_write;
      fill_req_once <= fill_once;
      fill_req_unified <= is_uni;
      fill_req_strong <= is_strong;
    end
  end

  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      map_req_valid <= 1'b0;
      map_req_addr <= phe_pkg::PHE_ADDR_RST;
      map_req_space <= phe_pkg::PHE_SPACE_RST;
    end else begin
      map_req_valid <= do_map;
      map_req_addr <= {rd_vblk, phe_pkg::PHE_BLK_BITS'(0)};
      map_req_space <= rd_space;
    end
  end

  // an abandoned hint leaves no trace but this pulse
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      late_drop <= 1'b0;
    end else begin
      late_drop <= do_drop;
    end
  end

  // ********************************
  // table occupancy
  // ********************************
  // allocation and release never hit the same slot: a slot is only freed
  // after its answer, which comes at least one cycle after its request
  always_comb begin
    busy_nxt = busy_r;
    if (s1_valid_r) begin
      busy_nxt[s1_tag_r] = 1'b0;
    end
    if (go) begin
      busy_nxt[free_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_r <= phe_pkg::PHE_BUSY_RST;
    end else begin
      busy_r <= busy_nxt;
    end
  end

endmodule

// >>> pkg/phe_pkg.sv
/*
  constants, types and field layout shared by the prefetch hint execution block.
  assumes a 32-bit instruction word, 64-bit integer registers and 8-bit space ids.
*/
// Contract
// - address is first plus second register, or first plus sign-extended 13-bit immediate
// - ordinary form targets primary space, big or little endian flavour
// - alternate form takes space from instruction field, or space register when flag set
// - prefetch never stalls issue; later instructions run while it is outstanding
// - no trap ever for illegal or nonexistent address
// - block fetched is 64 bytes, aligned on 64-byte boundary
// - codes 0-3 weak, 20-23 strong: several reads, one read, several writes, one write
// - code 4 requests a page mapping, code 17 fills nearest unified cache
// - codes 16, 18, 19, 24-31 and unimplemented codes act as no-ops
// - immediate flag clear with bits 12:5 nonzero raises illegal instruction
// - unprivileged alternate access to space 00-7F is a silent no-op
// - privileged alternate access to space 30-7F is a silent no-op
// - weak prefetch that misses translation is abandoned as no-op
// - only eight listed spaces accepted; any other space gives a no-op
// - codes 0-4, 17, 20-23 no-op on non-cacheable or side-effect mappings
// - codes 4 and 20-23 may no-op when the fetch would be very slow
// - no program-visible state changes beyond those of a no-op
// - defined codes raise only the illegal instruction exception listed
// - each defined code is no-op, full support, or simple common-case support
// - an effective prefetch moves the containing block or creates a mapping
// - weak prefetch drops when slow; strong may pay the cost and proceed
package phe_pkg;

  // ********************************
  // instruction fields
  // ********************************
  localparam int unsigned PHE_XLEN = 64;
  localparam int unsigned PHE_IFLAG_POS = 13;
  localparam int unsigned PHE_FCN_HI = 29;
  localparam int unsigned PHE_FCN_LO = 25;
  localparam int unsigned PHE_ASIF_HI = 12;
  localparam int unsigned PHE_ASIF_LO = 5;
  localparam int unsigned PHE_IMM_HI = 12;
  localparam int unsigned PHE_BLK_BITS = 6;

  // ********************************
  // variant codes
  // ********************************
  localparam logic [4:0] PHE_FCN_PAGE = 5'h04;
  localparam logic [4:0] PHE_FCN_RSV_LO = 5'h05;
  localparam logic [4:0] PHE_FCN_RSV_HI = 5'h0F;
  localparam logic [4:0] PHE_FCN_UNIFIED = 5'h11;
  // bit n set: code n implemented with full semantics, all others except reserved codes 5-15 (illegal) act as no-op
  localparam logic [31:0] PHE_IMPL_MASK = 32'h00F2001F;

  // ********************************
  // space identifiers
  // ********************************
  localparam logic [7:0] PHE_SPACE_PRIV_TOP = 8'h7F;
  localparam logic [7:0] PHE_SPACE_HYP_LO = 8'h30;
  localparam logic [7:0] PHE_NUCLEUS_SPACE = 8'h04;
  localparam logic [7:0] PHE_USER_VIEW_PRIMARY_SPACE = 8'h10;
  localparam logic [7:0] PHE_USER_VIEW_SECONDARY_SPACE = 8'h11;
  localparam logic [7:0] PHE_REAL_SPACE = 8'h14;
  localparam logic [7:0] PHE_PRIMARY_SPACE = 8'h80;
  localparam logic [7:0] PHE_SECONDARY_SPACE = 8'h81;
  localparam logic [7:0] PHE_PRIMARY_NOFAULT_SPACE = 8'h82;
  localparam logic [7:0] PHE_SECONDARY_NOFAULT_SPACE = 8'h83;
  localparam logic [7:0] PHE_PRIMARY_LITTLE_SPACE = 8'h88;

  // ********************************
  // outstanding table
  // ********************************
  localparam int unsigned PHE_TAG_W = 2;
  localparam int unsigned PHE_DEPTH = 4;
  localparam int unsigned PHE_VBLK_W = PHE_XLEN - PHE_BLK_BITS;
  localparam int unsigned PHE_ENT_W = 8 + 5 + PHE_VBLK_W;
  localparam logic [PHE_DEPTH-1:0] PHE_BUSY_RST = '0;
  localparam logic [PHE_ENT_W-1:0] PHE_ENT_RST = '0;
  localparam logic [PHE_XLEN-1:0] PHE_ADDR_RST = '0;
  localparam logic [7:0] PHE_SPACE_RST = 8'h00;
  localparam logic [PHE_TAG_W-1:0] PHE_TAG_RST = 2'h0;

  typedef enum logic [5:0] {
    PHE_CLS_ILLEGAL = 6'h01,
    PHE_CLS_NOP = 6'h02,
    PHE_CLS_WEAK = 6'h04,
    PHE_CLS_STRONG = 6'h08,
    PHE_CLS_PAGE = 6'h10,
    PHE_CLS_UNIFIED = 6'h20
  } phe_cls_t;

endpackage

// >>> sim/phe_assertions.sv
/*
  concurrent checks on the prefetch hint block ports.
  assumes one clock and the block's active-low reset.
*/
module phe_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic alt_form,
  input wire logic [7:0] space_id_register,
  input wire logic priv_mode,
  input wire logic illegal_instr,
  input wire logic noop_done,
  input wire logic xlate_req_valid,
  input wire logic xlate_rsp_valid,
  input wire logic xlate_rsp_miss,
  input wire logic physically_cacheable_flag,
  input wire logic virtually_cacheable_flag,
  input wire logic side_effect_flag,
  input wire logic late_drop
);
  // ****************
  // checks
  // ****************
  wire logic [4:0] fcn = instr[29:25];
  wire logic [7:0] spc = instr[13] ? space_id_register : instr[12:5];
  wire logic rsv = fcn inside {[5'h05:5'h0F]};
  wire logic bad = rsv || (!alt_form && !instr[13] && instr[12:5] != 8'h00);
  wire logic alt_ok = issue_valid && alt_form && !rsv;
  wire logic unc = !physically_cacheable_flag || !virtually_cacheable_flag || side_effect_flag;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_single_answer: assert property (issue_valid |=>
    $onehot({illegal_instr, noop_done, xlate_req_valid}))
    else $error("issue gave not exactly one answer");
  a_reserved_trap: assert property (issue_valid && rsv |=> illegal_instr)
    else $error("reserved code did not trap");
  a_bits_trap: assert property (issue_valid && !alt_form && !instr[13] &&
    |instr[12:5] |=> illegal_instr)
    else $error("nonzero bits 12:5 did not trap");
  a_no_other_trap: assert property (illegal_instr |-> $past(issue_valid) && $past(bad))
    else $error("trap without cause");
  a_impl_noop: assert property (issue_valid && !bad &&
    fcn inside {5'h10, 5'h12, 5'h13, [5'h18:5'h1F]} |=> noop_done)
    else $error("unimplemented code not a no-op");
  a_user_noop: assert property (alt_ok && !priv_mode && !spc[7] |=> noop_done)
    else $error("user low space not a no-op");
  a_hyper_noop: assert property (alt_ok && priv_mode &&
    spc inside {[8'h30:8'h7F]} |=> noop_done)
    else $error("privileged high space not a no-op");
  a_uncached_drop: assert property (xlate_rsp_valid && !xlate_rsp_miss && unc
    |-> ##2 late_drop)
    else $error("uncacheable mapping not dropped");
endmodule
bind phe_top phe_chk chk_u (.*);

// >>> sim/phe_mmu_model.sv
/*
  behavioural translation unit on the far side of the prefetch block.
  assumes the bench sets m_cfg {miss, slow, cp, cv, e} and m_delay before each request.
*/
module phe_mmu_model #(
  parameter logic [63:0] PA_XOR = 64'h0000_0F00_0000_0000
) (
  input wire logic clk,
  input wire logic xlate_req_valid,
  input wire logic [63:0] xlate_req_addr,
  input wire logic [1:0] xlate_req_tag,
  input wire logic [4:0] m_cfg,
  input wire logic [7:0] m_delay,
  output logic xlate_rsp_valid,
  output logic [1:0] xlate_rsp_tag,
  output logic xlate_rsp_miss,
  output logic xlate_rsp_slow,
  output logic physically_cacheable_flag,
  output logic virtually_cacheable_flag,
  output logic side_effect_flag,
  output logic [63:0] xlate_rsp_paddr
);
  // ****************
  // answer queue
  // ****************
  logic [70:0] rsp_r = '0;
  logic [70:0] q[$];
  int due[$];
  int cyc = 0;
  assign {xlate_rsp_miss, xlate_rsp_slow, physically_cacheable_flag, virtually_cacheable_flag,
    side_effect_flag, xlate_rsp_tag, xlate_rsp_paddr} = rsp_r;
  // idle fields toggle so a stale sample never passes for an answer
  always @(posedge clk) begin
    cyc <= cyc + 1;
    xlate_rsp_valid <= 1'b0;
    rsp_r <= ~rsp_r;
    if (due.size() > 0 && due[0] <= cyc) begin
      xlate_rsp_valid <= 1'b1;
      rsp_r <= q.pop_front() ^ {7'h00, PA_XOR};
      void'(due.pop_front());
    end
    if (xlate_req_valid) begin
      q.push_back({m_cfg, xlate_req_tag, xlate_req_addr});
      due.push_back(cyc + m_delay);
    end
  end
endmodule

// >>> sim/test_prefetch_hint_execution.sv
/*
  self-checking bench for the prefetch hint block.
  assumes the translation model answers after m_delay cycles with m_cfg flags.
*/
module test_prefetch_hint_execution;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] PXOR = 64'h0000_0F00_0000_0000;
  logic clk = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, alt_form = 1'b0;
  logic priv_mode = 1'b0, little_endian = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [63:0] first_source_register = 64'h0, second_source_register = 64'h0;
  logic [7:0] space_id_register = 8'h00, m_delay = 8'h01;
  logic [4:0] m_cfg = 5'h06;
  logic illegal_instr, noop_done, xlate_req_valid, xlate_rsp_valid, xlate_rsp_miss;
  logic xlate_rsp_slow, physically_cacheable_flag, virtually_cacheable_flag, side_effect_flag;
  logic fill_req_valid, fill_req_write, fill_req_once, fill_req_unified, fill_req_strong;
  logic map_req_valid, late_drop;
  logic [63:0] xlate_req_addr, xlate_rsp_paddr, fill_req_addr, map_req_addr, va, fa;
  logic [7:0] xlate_req_space, map_req_space, sp, ms;
  logic [1:0] xlate_req_tag, xlate_rsp_tag;
  logic [2:0] res;
  logic [3:0] fl;
  int failures = 0, samples_checked = 0, cycles = 0;
  phe_top dut_u (.*);
  phe_mmu_model #(.PA_XOR(PXOR)) mmu_u (.*);
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      end_sim();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one issue; e_out is {illegal, noop, xlate}, e_res is {fill, map, drop}
  task automatic op(input logic alt, input logic [4:0] fcn, input logic [13:0] low,
      input logic [63:0] a, input logic [2:0] e_out, input logic [2:0] e_res);
    @(posedge clk);
    issue_valid <= 1'b1;
    alt_form <= alt;
    instr <= {2'h0, fcn, 11'h000, low};
    first_source_register <= a;
    @(posedge clk);
    issue_valid <= 1'b0;
    instr <= ~instr;
    #1;
    va = xlate_req_addr;
    sp = xlate_req_space;
    check("issue outcome", {illegal_instr, noop_done, xlate_req_valid}, e_out);
    if (e_out == 3'h1) begin
      res = 3'h0;
      for (int i = 0; i < 40 && res == 3'h0; i++) begin
        @(posedge clk);
        #1;
        res = {fill_req_valid, map_req_valid, late_drop};
        fl = {fill_req_write, fill_req_once, fill_req_unified, fill_req_strong};
        fa = fill_req_valid ? fill_req_addr : map_req_addr;
        ms = map_req_space;
      end
      check("late outcome", res, e_res);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_addr();
    second_source_register <= 64'h0000_0000_0000_0155;
    op(1'b0, 5'h00, 14'h0000, 64'h1234_5678_9ABC_DEF0, 3'h1, 3'h4);
    check("register sum", va, 64'h1234_5678_9ABC_E040);
    check("primary space", sp, 8'h80);
    check("fill block", fa, 64'h1234_5678_9ABC_E040 ^ PXOR);
    little_endian <= 1'b1;
    op(1'b0, 5'h00, 14'h3FC0, 64'h0000_0000_0000_0105, 3'h1, 3'h4);
    check("immediate sum", va, 64'h0000_0000_0000_00C0);
    check("little space", sp, 8'h88);
    little_endian <= 1'b0;
    op(1'b0, 5'h00, 14'h0020, 64'h40, 3'h4, 3'h0);
    op(1'b0, 5'h14, 14'h1000, 64'h40, 3'h4, 3'h0);
    op(1'b0, 5'h01, 14'h001F, 64'h40, 3'h1, 3'h4);
    $display("address test done");
  endtask
  task automatic t_codes();
    logic [2:0] e_out;
    logic [3:0] e_fl;
    for (int f = 0; f < 32; f++) begin
      e_out = (f inside {[5:15]}) ? 3'h4 : (f inside {16, 18, 19, [24:31]}) ? 3'h2 : 3'h1;
      e_fl = {f[1] && f != 17, f[0] && f != 17, f == 17, f >= 20};
      op(1'b0, f[4:0], 14'h2000, 64'h4000, e_out, (f == 4) ? 3'h1 : 3'h4);
      if (e_out == 3'h1 && f != 4) check("fill intent", fl, e_fl);
    end
    $display("codes test done");
  endtask
  task automatic t_late();
    // rows of {code, {miss, slow, cp, cv, e}, outcome}
    logic [12:0] row [9] = '{{5'h00, 5'h16, 3'h1}, {5'h01, 5'h0E, 3'h1}, {5'h14, 5'h0E, 3'h4},
      {5'h15, 5'h16, 3'h1}, {5'h11, 5'h02, 3'h1}, {5'h02, 5'h04, 3'h1},
      {5'h17, 5'h07, 3'h1}, {5'h04, 5'h1E, 3'h1}, {5'h04, 5'h16, 3'h2}};
    foreach (row[k]) begin
      m_cfg <= row[k][7:3];
      op(1'b0, row[k][12:8], 14'h2000, 64'h1_2345, 3'h1, row[k][2:0]);
    end
    check("map address", fa, 64'h0000_0000_0001_2340);
    check("map space", ms, 8'h80);
    m_cfg <= 5'h06;
    $display("late test done");
  endtask
  task automatic t_space();
    logic [7:0] ok [8] = '{8'h04, 8'h10, 8'h11, 8'h14, 8'h80, 8'h81, 8'h82, 8'h83};
    priv_mode <= 1'b1;
    foreach (ok[k]) begin
      op(1'b1, 5'h00, {1'b0, ok[k], 5'h00}, 64'h8000, 3'h1, 3'h4);
      check("listed space", sp, ok[k]);
    end
    op(1'b1, 5'h00, 14'h05E0, 64'h8000, 3'h2, 3'h0);
    op(1'b1, 5'h00, 14'h0600, 64'h8000, 3'h2, 3'h0);
    space_id_register <= 8'h7F;
    op(1'b1, 5'h14, 14'h2000, 64'h8000, 3'h2, 3'h0);
    priv_mode <= 1'b0;
    op(1'b1, 5'h00, 14'h0080, 64'h8000, 3'h2, 3'h0);
    space_id_register <= 8'h83;
    op(1'b1, 5'h00, 14'h2FE0, 64'h8000, 3'h1, 3'h4);
    check("register space", sp, 8'h83);
    $display("space test done");
  endtask
  task automatic t_burst();
    int fills = 0;
    logic [3:0] tags = 4'h0;
    m_delay <= 8'h14;
    alt_form <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      issue_valid <= 1'b1;
      instr <= 32'h0000_2000;
      first_source_register <= 64'(k) << 6;
      #1;
      if (k > 0) check("burst accept", xlate_req_valid, 1'b1);
      if (k > 0) tags[xlate_req_tag] = 1'b1;
    end
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    check("table full", noop_done, 1'b1);
    check("burst tags", tags, 4'hF);
    repeat (30) begin
      @(posedge clk);
      #1;
      fills += fill_req_valid;
    end
    check("burst fills", fills, 4);
    m_delay <= 8'h01;
    $display("burst test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_addr();
    t_codes();
    t_late();
    t_space();
    t_burst();
    end_sim();
  end
endmodule
